// [core/hwc_halt_wake.sv]
// Purpose: Halt flavour choice, clock gating and wake sequencing.
// Assumes: The auto-wake RC clock is slow beside core_clk.
// Notes: The RC clock is sampled as a plain input, not used as a clock.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps

module hwc_halt_wake
  import hwc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction decode from the CPU core.
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  // Timer settings and wake requests.
  input wire hwc_timer_cfg_t timer_cfg,
  input wire hwc_wake_irq_t wake_irq,
  // Watchdog state and its option bit.
  input wire logic watchdog_active,
  input wire logic watchdog_halt_option,
  // Auto-wake RC oscillator output.
  input wire logic awu_rc_clk,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock gates, CPU events and wake interrupt.
  output hwc_clk_gate_t clk_gate,
  output hwc_cpu_evt_t cpu_evt,
  output logic awu_capture_route,
  output logic awu_irq,
  output hwc_mode_t mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True in any of the three halt modes.
  function automatic logic is_halted(input hwc_mode_t m);
    is_halted = (m == ST_ACTIVE) || (m == ST_FULL) || (m == ST_AWU);
  endfunction

  // Register state and its next value.
  hwc_state_t st;
  hwc_state_t next_st;

  // Decoded conditions shared by the next-state logic and the checks.
  logic halt_fetch;
  logic active_sel;
  logic wdg_reset_cond;
  logic rc_rise;
  logic [13:0] awu_target;
  logic awu_expire;
  logic csr_read;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding.

  assign halt_fetch = opcode_valid && (opcode == HALT_OPCODE);

  assign active_sel = timer_cfg.timebase_irq_enable ||
                      (timer_cfg.overflow_irq_enable &&
                       !timer_cfg.counter_clock_sel_hi &&
                       timer_cfg.counter_clock_sel_lo);

  // Timer-kept halt exempt.
  // Only the oscillator-stopping flavours can starve the watchdog, so they
  // alone turn into a reset when the option bit is clear.
  assign wdg_reset_cond = watchdog_active && !watchdog_halt_option &&
                          (st.auto_wake_enable || !active_sel);

  // Edge seen only past the second stage.
  assign rc_rise = st.rc_sync[1] && !st.rc_prev;

  assign awu_target = 14'(st.wake_prescaler) * AWU_FIXED_DIV;
  assign awu_expire = (st.mode == ST_AWU) && rc_rise &&
                      ((st.awu_cnt + 14'h0001) == awu_target);

  assign csr_read = reg_rd && (reg_addr == ADDR_WAKE_CSR);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // All behaviour lives here; the flop process below only stores it.
  always_comb begin
    next_st = st;
    next_st.evt = '0;
    // The first sync stage feeds only the second.
    next_st.rc_sync = {st.rc_sync[0], awu_rc_clk};
    next_st.rc_prev = st.rc_sync[1];

    // Register writes.
    if (reg_wr && (reg_addr == ADDR_WAKE_CSR)) begin
      next_st.auto_wake_enable = reg_wdata[CSR_ENABLE_BIT];
      next_st.auto_wake_measure = reg_wdata[CSR_MEASURE_BIT];
    end
    if (reg_wr && (reg_addr == ADDR_WAKE_PR) && (reg_wdata != PR_FORBIDDEN)) begin
      next_st.wake_prescaler = reg_wdata;
    end

    // Read data stand in the following cycle only; unmapped reads give 0.
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_WAKE_CSR: begin
          next_st.rdata[CSR_ENABLE_BIT] = st.auto_wake_enable;
          next_st.rdata[CSR_MEASURE_BIT] = st.auto_wake_measure;
          next_st.rdata[CSR_FLAG_BIT] = st.auto_wake_flag;
        end
        ADDR_WAKE_PR: next_st.rdata = st.wake_prescaler;
        ADDR_HALT_STATUS: next_st.rdata = {5'h00, st.mode};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Read clears flag.
    // Set wins over clear: an expiry in the read cycle stays visible.
    if (csr_read) begin
      next_st.auto_wake_flag = 1'b0;
    end

    unique case (st.mode)
      // Stabilisation after reset, then the reset vector.
      ST_RST_STAB: begin
        next_st.stab_cnt = st.stab_cnt + 8'h01;
        if (st.stab_cnt == STAB_LAST) begin
          next_st.mode = ST_RUN;
          next_st.evt.fetch_reset_vector = 1'b1;
        end
      end
      // Normal execution.
      ST_RUN: begin
        if (halt_fetch) begin
          if (wdg_reset_cond) begin
            next_st.evt.watchdog_reset_req = 1'b1;
          end else begin
            next_st.evt.irq_mask_clear = 1'b1;
            next_st.awu_cnt = 14'h0000;
            if (st.auto_wake_enable) begin
              next_st.mode = ST_AWU;
            end else if (active_sel) begin
              next_st.mode = ST_ACTIVE;
            end else begin
              next_st.mode = ST_FULL;
            end
          end
        end
      end
      // Oscillator kept running; a lite_rtc or reload_timer request resumes at once.
      ST_ACTIVE: begin
        if (wake_irq.lite_rtc || wake_irq.reload_timer) begin
          next_st.mode = ST_RUN;
          next_st.evt.resume_irq = 1'b1;
        end
      end
      // Oscillator stopped; only capable interrupts wake.
      ST_FULL: begin
        if (wake_irq.halt_exit) begin
          next_st.mode = ST_IRQ_STAB;
          next_st.stab_cnt = 8'h00;
        end
      end
      // Oscillator stopped; the RC delay or a capable interrupt wakes.
      ST_AWU: begin
        if (rc_rise) begin
          next_st.awu_cnt = st.awu_cnt + 14'h0001;
        end
        if (awu_expire) begin
          next_st.auto_wake_flag = 1'b1;
        end
        if (awu_expire || wake_irq.halt_exit) begin
          next_st.mode = ST_IRQ_STAB;
          next_st.stab_cnt = 8'h00;
        end
      end
      // Stabilisation before servicing the waking interrupt.
      ST_IRQ_STAB: begin
        next_st.stab_cnt = st.stab_cnt + 8'h01;
        if (st.stab_cnt == STAB_LAST) begin
          next_st.mode = ST_RUN;
          next_st.evt.resume_irq = 1'b1;
        end
      end
      // Illegal codes recover through the reset stabilisation and vector fetch, keeping the registers.
      default: begin
        next_st.mode = ST_RST_STAB;
        next_st.stab_cnt = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset loads constants only; a reset leaves by way of stabilisation.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mode: ST_RST_STAB, stab_cnt: 8'h00, awu_cnt: 14'h0000,
              wake_prescaler: PR_RESET, auto_wake_enable: 1'b0,
              auto_wake_measure: 1'b0, auto_wake_flag: 1'b0, rdata: 8'h00,
              rc_sync: 2'b00, rc_prev: 1'b0, evt: '0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign reg_rdata = st.rdata;
  assign cpu_evt = st.evt;
  assign mode = st.mode;
  assign awu_irq = st.auto_wake_flag;
  assign awu_capture_route = st.auto_wake_measure && (st.mode == ST_RUN);

  // Gates are decoded from the stored mode, so they never glitch on inputs.
  // Clock gates per mode.
  assign clk_gate.cpu = (st.mode == ST_RUN);
  assign clk_gate.periph = (st.mode == ST_RUN);
  assign clk_gate.timer = (st.mode == ST_RUN) || (st.mode == ST_ACTIVE);
  assign clk_gate.main_osc = !((st.mode == ST_FULL) || (st.mode == ST_AWU));
  assign clk_gate.awu_rc = (st.mode == ST_AWU) || awu_capture_route;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A halt opcode in run with no watchdog veto.
  sequence s_clean_halt;
    st.mode == ST_RUN && halt_fetch && !wdg_reset_cond;
  endsequence

  // Entry from run into any halt mode.
  sequence s_halt_entry;
    st.mode == ST_RUN ##1 is_halted(st.mode);
  endsequence

  property p_halt_choice;
    s_clean_halt |=> st.mode == ($past(st.auto_wake_enable) ? ST_AWU :
                     ($past(active_sel) ? ST_ACTIVE : ST_FULL));
  endproperty
  a_halt_choice: assert property (p_halt_choice)
    else $error("halt mode choice wrong");

  property p_active_hold;
    st.mode == ST_ACTIVE && !wake_irq.lite_rtc && !wake_irq.reload_timer
      |=> st.mode == ST_ACTIVE;
  endproperty
  a_active_hold: assert property (p_active_hold)
    else $error("timer-kept halt left without cause");

  property p_active_resume;
    st.mode == ST_ACTIVE && (wake_irq.lite_rtc || wake_irq.reload_timer)
      |=> st.mode == ST_RUN && cpu_evt.resume_irq;
  endproperty
  a_active_resume: assert property (p_active_resume)
    else $error("timer-kept wake not immediate");

  // Anchored on the first counted cycle: a count of zero also stands in the
  // release edge itself, where the disable condition may already be gone.
  property p_reset_stab;
    st.mode == ST_RST_STAB && st.stab_cnt == 8'h01
      |-> ##255 (st.mode == ST_RUN && cpu_evt.fetch_reset_vector);
  endproperty
  a_reset_stab: assert property (p_reset_stab)
    else $error("reset stabilisation length wrong");

  property p_irq_stab;
    st.mode == ST_IRQ_STAB && st.stab_cnt == 8'h00
      |-> ##256 (st.mode == ST_RUN && cpu_evt.resume_irq);
  endproperty
  a_irq_stab: assert property (p_irq_stab)
    else $error("wake stabilisation length wrong");

  property p_mask_clear;
    s_halt_entry |-> cpu_evt.irq_mask_clear;
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("mask not cleared on halt entry");

  property p_active_clocks;
    st.mode == ST_ACTIVE |-> clk_gate.main_osc && clk_gate.timer &&
                             !clk_gate.periph && !clk_gate.cpu;
  endproperty
  a_active_clocks: assert property (p_active_clocks)
    else $error("timer-kept clock gating wrong");

  property p_osc_off;
    (st.mode == ST_FULL || st.mode == ST_AWU) |-> !clk_gate.main_osc &&
                                                  !clk_gate.periph;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator running in deep halt");

  property p_wdg_reset;
    st.mode == ST_RUN && halt_fetch && wdg_reset_cond
      |=> cpu_evt.watchdog_reset_req && st.mode == ST_RUN;
  endproperty
  a_wdg_reset: assert property (p_wdg_reset)
    else $error("watchdog halt reset missing");

  property p_pr_zero;
    reg_wr && reg_addr == ADDR_WAKE_PR && reg_wdata == PR_FORBIDDEN
      |=> st.wake_prescaler == $past(st.wake_prescaler);
  endproperty
  a_pr_zero: assert property (p_pr_zero)
    else $error("zero prescaler write took effect");

  property p_flag_read;
    csr_read && !awu_expire |=> !awu_irq;
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("status read left flag set");

  property p_awu_expire;
    awu_expire |=> awu_irq && st.mode == ST_IRQ_STAB && st.stab_cnt == 8'h00;
  endproperty
  a_awu_expire: assert property (p_awu_expire)
    else $error("auto-wake expiry sequence wrong");

  property p_full_hold;
    st.mode == ST_FULL && !wake_irq.halt_exit |=> st.mode == ST_FULL;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full halt left without cause");

  property p_awu_count;
    st.mode == ST_AWU && rc_rise |=> st.awu_cnt == $past(st.awu_cnt) + 14'h0001;
  endproperty
  a_awu_count: assert property (p_awu_count)
    else $error("auto-wake edge not counted");

  property p_wdg_exempt;
    st.mode == ST_RUN && halt_fetch && active_sel && !st.auto_wake_enable
      |=> !cpu_evt.watchdog_reset_req && st.mode == ST_ACTIVE;
  endproperty
  a_wdg_exempt: assert property (p_wdg_exempt)
    else $error("timer-kept halt gave a watchdog reset");

endmodule // hwc_halt_wake

// [dv/hwc_far_side_model.sv]
// Purpose: Far side model: interrupt controller latches and the RC oscillator.
// Assumes: Requests from the bench are one-cycle pulses on core_clk.
// Notes: The RC clock finishes its current period, then stands still low, once its gate is closed.
`timescale 1ns/1ps

module hwc_far_side_model
  import hwc_pkg::*;
#(
  parameter int RC_HALF_NS = 470
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Bench requests and controller state.
  input wire hwc_wake_irq_t req,
  input wire hwc_clk_gate_t clk_gate,
  input wire hwc_cpu_evt_t cpu_evt,
  input wire logic awu_capture_route,
  // Pending requests, RC clock and its edge count.
  output hwc_wake_irq_t wake_irq,
  output logic awu_rc_clk,
  output int rc_edges
);
  ////////////////////////////////////////////////////////////////////////
  // Requests stay pending until the core services one; this is what makes
  // a request raised before a halt still visible when the halt begins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq <= '0;
    end else if (cpu_evt.resume_irq) begin
      wake_irq <= '0;
    end else begin
      wake_irq <= wake_irq | req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The RC runs only while enabled, so counts start at auto-wake halt entry or when the measure route opens.
  // One process drives the RC pin and its count, so each has one driver.
  initial begin
    awu_rc_clk = 1'b0;
    rc_edges = 0;
    forever begin
      wait (clk_gate.awu_rc || awu_capture_route);
      #RC_HALF_NS awu_rc_clk = 1'b1;
      rc_edges++;
      #RC_HALF_NS awu_rc_clk = 1'b0;
    end
  end
endmodule // hwc_far_side_model

// [dv/tb_hwc_halt_wake.sv]
// Purpose: Self-checking bench of the halt and wake controller.
// Assumes: 10 MHz core clock; bench drives inputs by NBA at rising edges.
// Notes: Prescaler 01 keeps the auto-wake delay to 64 RC periods.
`timescale 1ns/1ps

module tb_hwc_halt_wake;
  import hwc_pkg::*;
  // Bench-driven inputs.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic opcode_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  hwc_timer_cfg_t timer_cfg = '0;
  logic watchdog_active = 1'b0;
  logic watchdog_halt_option = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  hwc_wake_irq_t req = '0;
  // Outputs of the design and of the partner.
  hwc_wake_irq_t wake_irq;
  logic awu_rc_clk;
  logic [7:0] reg_rdata;
  hwc_clk_gate_t clk_gate;
  hwc_cpu_evt_t cpu_evt;
  logic awu_capture_route;
  logic awu_irq;
  hwc_mode_t mode;
  int rc_edges;
  int n_errors = 0;
  int n_tests = 0;

  hwc_halt_wake i_hwc_halt_wake (.core_clk(core_clk), .rst_n(rst_n),
    .opcode_valid(opcode_valid), .opcode(opcode), .timer_cfg(timer_cfg),
    .wake_irq(wake_irq), .watchdog_active(watchdog_active),
    .watchdog_halt_option(watchdog_halt_option), .awu_rc_clk(awu_rc_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_gate(clk_gate), .cpu_evt(cpu_evt),
    .awu_capture_route(awu_capture_route), .awu_irq(awu_irq), .mode(mode));

  hwc_far_side_model i_hwc_far_side_model (.core_clk(core_clk), .rst_n(rst_n),
    .req(req), .clk_gate(clk_gate), .cpu_evt(cpu_evt),
    .awu_capture_route(awu_capture_route), .wake_irq(wake_irq),
    .awu_rc_clk(awu_rc_clk), .rc_edges(rc_edges));

  ////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period.
  always #50 core_clk = ~core_clk;

  // Compares one value exactly; an unknown bit matches only an unknown bit.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, then data sampled in the following cycle only.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask

  // Presents an opcode for one cycle; returns after the taking edge settled.
  task automatic halt(input logic [7:0] op);
    @(posedge core_clk);
    opcode_valid <= 1'b1;
    opcode <= op;
    @(posedge core_clk);
    opcode_valid <= 1'b0;
    #1;
  endtask

  // Counts edges until the resume pulse, bounded against a hang.
  task automatic to_resume(output int n);
    n = 0;
    while (cpu_evt.resume_irq !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
      #1;
    end
  endtask

  // Pulses a request to the partner, then counts to the resume.
  task automatic raise(input hwc_wake_irq_t r, output int n);
    @(posedge core_clk);
    req <= r;
    @(posedge core_clk);
    req <= '0;
    to_resume(n);
  endtask

  // Reset for 16 cycles, then the stabilisation count to the vector fetch.
  task automatic do_reset();
    int n;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    n = 0;
    while (cpu_evt.fetch_reset_vector !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
      #1;
    end
    chk(16'(n), 16'd256);
    chk(16'(mode), 16'(ST_RUN));
    chk(16'(clk_gate), 16'h001e);
  endtask

  // Single closing point of the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need just under 4000 cycles.
  initial begin
    #(30000 * 100);
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    logic act;
    do_reset();
    rdc(ADDR_WAKE_CSR, 8'h00);
    rdc(ADDR_WAKE_PR, PR_RESET);
    rdc(8'h30, 8'h00);
    rdc(ADDR_HALT_STATUS, 8'(ST_RUN));
    wr(ADDR_WAKE_PR, PR_FORBIDDEN);
    rdc(ADDR_WAKE_PR, PR_RESET);
    wr(ADDR_WAKE_PR, 8'h01);
    rdc(ADDR_WAKE_PR, 8'h01);
    // Flag bit written too; only the measure bit may stick.
    wr(ADDR_WAKE_CSR, 8'h06);
    rdc(ADDR_WAKE_CSR, 8'h02);
    chk(16'(awu_capture_route), 16'h1);
    wr(ADDR_WAKE_CSR, 8'h00);
    halt(8'h8f);
    chk(16'(mode), 16'(ST_RUN));
    $display("test registers done");
    // Every timer setting, each offered a wrong request, then woken once by a right one.
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      timer_cfg <= hwc_timer_cfg_t'(4'(i));
      act = i[3] | (i[2] & !i[1] & i[0]);
      // Software is taken to have slowed the CPU clock already.
      halt(HALT_OPCODE);
      chk(16'(mode), act ? 16'(ST_ACTIVE) : 16'(ST_FULL));
      chk(16'(cpu_evt.irq_mask_clear), 16'h1);
      chk(16'(clk_gate), act ? 16'h000a : 16'h0000);
      @(posedge core_clk);
      req <= act ? 3'b001 : 3'b110;
      @(posedge core_clk);
      req <= '0;
      repeat (3) @(posedge core_clk);
      #1 chk(16'(mode), act ? 16'(ST_ACTIVE) : 16'(ST_FULL));
      raise(act ? (i[0] ? 3'b010 : 3'b100) : 3'b001, n);
      chk(16'(n), act ? 16'd1 : 16'd257);
    end
    $display("test halt choice done");
    // Watchdog option cleared: full halt becomes a reset, timer-kept not.
    @(posedge core_clk);
    watchdog_active <= 1'b1;
    watchdog_halt_option <= 1'b0;
    timer_cfg <= '0;
    halt(HALT_OPCODE);
    chk(16'(cpu_evt.watchdog_reset_req), 16'h1);
    chk(16'(mode), 16'(ST_RUN));
    @(posedge core_clk);
    timer_cfg <= 4'b1000;
    halt(HALT_OPCODE);
    chk(16'(cpu_evt.watchdog_reset_req), 16'h0);
    raise(3'b100, n);
    @(posedge core_clk);
    watchdog_active <= 1'b0;
    $display("test watchdog done");
    // Auto-wake wins over the timer setting and expires after 64 RC edges.
    wr(ADDR_WAKE_CSR, 8'h01);
    halt(HALT_OPCODE);
    chk(16'(mode), 16'(ST_AWU));
    chk(16'(clk_gate), 16'h0001);
    n = rc_edges;
    for (int k = 0; k < 3000 && mode !== ST_IRQ_STAB; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk(16'(rc_edges - n), 16'd64);
    chk(16'(awu_irq), 16'h1);
    to_resume(n);
    chk(16'(n), 16'd256);
    rdc(ADDR_WAKE_CSR, 8'h05);
    chk(16'(awu_irq), 16'h0);
    rdc(ADDR_WAKE_CSR, 8'h01);
    // Exit of auto-wake halt by a capable interrupt before expiry.
    halt(HALT_OPCODE);
    raise(3'b001, n);
    chk(16'(n), 16'd257);
    chk(16'(awu_irq), 16'h0);
    wr(ADDR_WAKE_CSR, 8'h00);
    $display("test auto wake done");
    // Reset out of timer-kept halt.
    halt(HALT_OPCODE);
    chk(16'(mode), 16'(ST_ACTIVE));
    do_reset();
    $display("test reset exit done");
    report_and_stop();
  end
endmodule // tb_hwc_halt_wake

// [shared/hwc_pkg.sv]
// Purpose: Shared constants and types of the halt and wake controller.
// Assumes: One 10 MHz core clock; registers on an 8-bit plain port.
// Notes: Offsets are byte addresses on the plain register port.
package hwc_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_WAKE_CSR = 8'h48;
  localparam logic [7:0] ADDR_WAKE_PR = 8'h49;
  localparam logic [7:0] ADDR_HALT_STATUS = 8'h4a;

  // Field positions in the wake control/status register.
  localparam int CSR_ENABLE_BIT = 0;
  localparam int CSR_MEASURE_BIT = 1;
  localparam int CSR_FLAG_BIT = 2;

  // Prescaler value after reset, and the value a write may not set.
  localparam logic [7:0] PR_RESET = 8'hff;
  localparam logic [7:0] PR_FORBIDDEN = 8'h00;

  // The opcode that requests a halt.
  localparam logic [7:0] HALT_OPCODE = 8'h8e;

  // Oscillator stabilisation, in CPU cycles, and the last count value.
  localparam int STAB_CYCLES = 256;
  localparam logic [7:0] STAB_LAST = 8'(STAB_CYCLES - 1);

  // Fixed divider ahead of the wake prescaler, in RC periods.
  localparam logic [13:0] AWU_FIXED_DIV = 14'h0040;

  // Operating modes of the controller.
  typedef enum logic [2:0] {
    ST_RST_STAB = 3'b000,
    ST_RUN = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_FULL = 3'b011,
    ST_AWU = 3'b100,
    ST_IRQ_STAB = 3'b101
  } hwc_mode_t;

  // Timer settings that choose the halt flavour.
  typedef struct packed {
    logic timebase_irq_enable;
    logic overflow_irq_enable;
    logic counter_clock_sel_hi;
    logic counter_clock_sel_lo;
  } hwc_timer_cfg_t;

  // Interrupt requests that may end a halt.
  typedef struct packed {
    logic lite_rtc;
    logic reload_timer;
    logic halt_exit;
  } hwc_wake_irq_t;

  // Clock and oscillator gates.
  typedef struct packed {
    logic cpu;
    logic main_osc;
    logic periph;
    logic timer;
    logic awu_rc;
  } hwc_clk_gate_t;

  // One-cycle events towards the CPU core.
  typedef struct packed {
    logic irq_mask_clear;
    logic resume_irq;
    logic fetch_reset_vector;
    logic watchdog_reset_req;
  } hwc_cpu_evt_t;

  // Complete state of the controller.
  typedef struct packed {
    hwc_mode_t mode;
    logic [7:0] stab_cnt;
    logic [13:0] awu_cnt;
    logic [7:0] wake_prescaler;
    logic auto_wake_enable;
    logic auto_wake_measure;
    logic auto_wake_flag;
    logic [7:0] rdata;
    logic [1:0] rc_sync;
    logic rc_prev;
    hwc_cpu_evt_t evt;
  } hwc_state_t;

endpackage
